// ===== bench/raw_alarm_wdog_test.sv
// self-checking bench: alarm matching, test wave and watchdog timing
`timescale 1ns/1ps
`default_nettype none
`include "raw_params.svh"
module raw_alarm_wdog_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic pwr = 1'b0;
	logic batt = 1'b0;
	logic stk = 1'b0;
	logic [7:0] tim [4];
	logic [7:0] alm [4];
	logic ce_n, oe_n, we_n, dq_oe, irq_v, irq_oe, rst_v, rst_oe, osc_stop, ft, seen;
	logic [16:0] addr;
	logic [7:0] dq_h, dq_d, q;
	wire logic [7:0] dq_w;
	int num_errors = 0;
	int n_checks = 0;
	int n;
	logic [3:0] mc;
	logic hit;
	int lim [4] = '{60, 60, 24, 31};
	logic [7:0] wm [4] = '{8'h7F, 8'h7F, 8'h3F, 8'h3F};
	logic [3:0] codes [7] = '{4'hF, 4'hE, 4'hC, 4'h8, 4'h0, 4'h5, 4'hA};
	logic [7:0] wdv [3] = '{8'h04, 8'h08, 8'h05};
	int wdc [3] = '{4096, 8192, 16384};
	logic [7:0] ftv [3] = '{8'h00, 8'h0A, 8'h8A};
	int ftl [3] = '{19, 0, 19};
	int fth [3] = '{21, 0, 21};
	assign dq_w = dq_oe ? dq_d : dq_h;
	always #2 clk_i = ~clk_i;
	raw_host_model raw_host_model_i (.clk_i(clk_i), .ce_n_o(ce_n), .oe_n_o(oe_n),
		.we_n_o(we_n), .addr_o(addr), .dq_o(dq_h), .dq_i(dq_w), .dq_oe_i(dq_oe));
	// fast oscillator (2 clocks a tick) and a short reset pulse keep the run brief
	raw_alarm_wdog #(.RST_PULSE_CYC(20), .CLK_HZ(64), .OSC_HZ(32)) raw_alarm_wdog_i (
		.clk_i(clk_i), .rst_i(rst_i), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
		.addr_i(addr), .dq_i(dq_w), .dq_o(dq_d), .dq_oe_o(dq_oe),
		.irq_or_test_out_o(irq_v), .irq_or_test_out_oe_o(irq_oe), .reset_n_o(rst_v),
		.reset_n_oe_o(rst_oe), .power_up_i(pwr), .on_battery_i(batt), .sec_tick_i(stk),
		.time_sec_i(tim[0]), .time_min_i(tim[1]), .time_hour_i(tim[2]),
		.time_date_i(tim[3]), .osc_stop_o(osc_stop), .freq_test_o(ft));
	task automatic finish_test();
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		chk(nm, {7'h00, e}, {7'h00, g});
	endtask
	task automatic rchk(input string nm, input int lo, input int hi, input int g);
		n_checks++;
		if (g < lo || g > hi) begin
			num_errors++;
			$display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask
	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		raw_host_model_i.access(1'b1, a, d, q, seen);
	endtask
	task automatic rd(input logic [16:0] a, input logic [7:0] e, input string nm);
		raw_host_model_i.access(1'b0, a, 8'h00, q, seen);
		chk1({nm, " drive"}, 1'b1, seen);
		chk(nm, e, q);
	endtask
	task automatic tick();
		@(posedge clk_i);
		#1;
		stk = 1'b1;
		@(posedge clk_i);
		#1;
		stk = 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic waitfor(input logic sel, input int lm, output int c);
		c = 0;
		while ((sel ? rst_oe : irq_oe) !== 1'b1 && c < lm) begin
			@(posedge clk_i);
			#1;
			c++;
		end
	endtask
	task automatic toggles(input int cyc, output int c);
		logic p;
		c = 0;
		p = irq_oe;
		repeat (cyc) begin
			@(posedge clk_i);
			#1;
			if (irq_oe !== p) c++;
			p = irq_oe;
		end
	endtask
	function automatic logic [7:0] bcd(input int v);
		return 8'((v / 10) * 16 + v % 10);
	endfunction
	function automatic logic alarm_hit(input logic [3:0] m);
		int k;
		k = (m == 4'hE) ? 1 : (m == 4'hC) ? 2 : (m == 4'h8) ? 3 : (m == 4'h0) ? 4 : 0;
		for (int i = 0; i < k; i++) begin
			if (((alm[i] ^ tim[i]) & wm[i]) != 8'h00) return 1'b0;
		end
		return 1'b1;
	endfunction
	initial begin
		#400000;
		num_errors++;
		finish_test();
	end
	initial begin
		tim = '{8'h00, 8'h00, 8'h00, 8'h01};
		void'($urandom(94509));
		repeat (6) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		chk1("osc_stop", 1'b1, osc_stop);
		chk1("ft reset", 1'b0, ft);
		rd(`RAW_OFS_ENABLES, 8'h00, "enables");
		rd(`RAW_OFS_WDOG, 8'h00, "wdog");
		wr(`RAW_OFS_SECONDS, 8'h00);
		chk1("osc_stop", 1'b0, osc_stop);
		wr(`RAW_OFS_ENABLES, 8'h80);
		for (int k = 0; k < 14; k++) begin
			mc = codes[k % 7];
			for (int i = 0; i < 4; i++) begin
				n = $urandom_range(lim[i] - 1);
				tim[i] = bcd(n + (i == 3));
				alm[i] = $urandom_range(1) ? tim[i] : bcd((n + 1) % lim[i] + (i == 3));
				wr(17'(`RAW_OFS_ALM_SEC + i), alm[i] | {mc[i], 7'h00});
			end
			hit = alarm_hit(mc);
			tick();
			chk1("alarm irq", hit, irq_oe);
			rd(`RAW_OFS_FLAGS, {1'b0, hit, 6'h00}, "flags");
			chk1("irq after flags", 1'b0, irq_oe);
			rd(`RAW_OFS_FLAGS, 8'h00, "flags cleared");
		end
		for (int i = 0; i < 4; i++) wr(17'(`RAW_OFS_ALM_SEC + i), 8'h80);
		batt = 1'b1;
		for (int b = 0; b < 2; b++) begin
			wr(`RAW_OFS_ENABLES, b ? 8'hA0 : 8'h80);
			tick();
			chk1("battery irq", b[0], irq_oe);
			rd(`RAW_OFS_FLAGS, 8'h40, "battery flags");
		end
		batt = 1'b0;
		wr(`RAW_OFS_ENABLES, 8'hA0);
		wr(`RAW_OFS_WDOG, 8'h05);
		wr(`RAW_OFS_DAY, 8'h40);
		chk1("ft set", 1'b1, ft);
		pwr = 1'b1;
		repeat (4) @(posedge clk_i);
		tick();
		chk1("pwr irq", 1'b0, irq_oe);
		#1;
		pwr = 1'b0;
		repeat (4) @(posedge clk_i);
		rd(`RAW_OFS_ENABLES, 8'h00, "pwr enables");
		rd(`RAW_OFS_WDOG, 8'h00, "pwr wdog");
		chk1("pwr ft", 1'b0, ft);
		rd(`RAW_OFS_FLAGS, 8'h40, "pwr flags");
		wr(`RAW_OFS_DAY, 8'h40);
		for (int i = 0; i < 3; i++) begin
			wr(`RAW_OFS_WDOG, ftv[i]);
			repeat (8) @(posedge clk_i);
			#1;
			toggles(1280, n);
			rchk("test wave edges", ftl[i], fth[i], n);
		end
		wr(`RAW_OFS_DAY, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(`RAW_OFS_WDOG, wdv[i]);
			repeat (2000) @(posedge clk_i);
			#1;
			chk1("no early expiry", 1'b0, irq_oe);
			rd(`RAW_OFS_WDOG, wdv[i], "wdog restart");
			waitfor(1'b0, 20000, n);
			rchk("wdog period", wdc[i] - 40, wdc[i] + 10, n);
			repeat (50) @(posedge clk_i);
			#1;
			chk1("wdog irq held", 1'b1, irq_oe);
			chk1("irq pin value", 1'b0, irq_v);
			rd(`RAW_OFS_FLAGS, 8'h80, "wdog flags");
			chk1("wdog irq cleared", 1'b0, irq_oe);
			wr(`RAW_OFS_WDOG, 8'h00);
		end
		wr(`RAW_OFS_DAY, 8'h40);
		wr(`RAW_OFS_WDOG, 8'h84);
		waitfor(1'b1, 5000, n);
		chk1("reset pin value", 1'b0, rst_v);
		rchk("reset delay", 4056, 4106, n);
		n = 0;
		while (rst_oe === 1'b1 && n < 100) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		rchk("reset pulse", 20, 21, n);
		repeat (2) @(posedge clk_i);
		#1;
		chk1("ft after pulse", 1'b0, ft);
		rd(`RAW_OFS_WDOG, 8'h00, "wdog after pulse");
		rd(`RAW_OFS_FLAGS, 8'h80, "steer flags");
		wr(`RAW_OFS_WDOG, 8'h04);
		wr(`RAW_OFS_WDOG, 8'h00);
		repeat (6000) @(posedge clk_i);
		#1;
		chk1("disabled irq", 1'b0, irq_oe);
		chk1("disabled reset", 1'b0, rst_oe);
		raw_host_model_i.access(1'b0, 17'h00010, 8'h00, q, seen);
		chk1("unmapped drive", 1'b0, seen);
		finish_test();
	end
endmodule
`default_nettype wire

// ===== bench/raw_host_model.sv
// host processor model on the asynchronous memory bus
`timescale 1ns/1ps
`default_nettype none
module raw_host_model (
	input wire logic clk_i,
	output logic ce_n_o,
	output logic oe_n_o,
	output logic we_n_o,
	output logic [16:0] addr_o,
	output logic [7:0] dq_o,
	input wire logic [7:0] dq_i,
	input wire logic dq_oe_i
);
	initial begin
		ce_n_o = 1'b1;
		oe_n_o = 1'b1;
		we_n_o = 1'b1;
		addr_o = 17'h00000;
		dq_o = 8'hFF;
	end
	// pins pass two sync stages, so each access is held 5 clocks and followed by 4 idle
	// a periodic access to the watchdog register is how the host keeps the watchdog from expiring
	task automatic access(input logic wr, input logic [16:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic seen);
		@(posedge clk_i);
		#1;
		ce_n_o = 1'b0;
		oe_n_o = wr;
		we_n_o = !wr;
		addr_o = a;
		dq_o = d;
		repeat (5) @(posedge clk_i);
		#1;
		q = dq_i;
		seen = dq_oe_i;
		ce_n_o = 1'b1;
		oe_n_o = 1'b1;
		we_n_o = 1'b1;
		// released lines show the inverse so a stale value cannot pass
		addr_o = ~a;
		dq_o = ~d;
		repeat (4) @(posedge clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

// ===== include/raw_core_if.sv
// ticks and reset-pulse handshake between the core and its helpers
`timescale 1ns/1ps
`default_nettype none
interface raw_core_if;
	logic run;
	logic restart;
	logic osc_tick;
	logic sq_wave;
	logic [3:0] res_tick;
	logic pulse_start;
	logic pulse_busy;
	logic pulse_done;
	modport div(input run, input restart, output osc_tick, output sq_wave, output res_tick);
	modport pulse(input pulse_start, output pulse_busy, output pulse_done);
	modport core(output run, output restart, output pulse_start, input osc_tick, input sq_wave,
		input res_tick, input pulse_busy, input pulse_done);
endinterface
`default_nettype wire

// ===== include/raw_params.svh
// register map, field positions, reset values and timing counts of the alarm/watchdog block
`ifndef RAW_PARAMS_SVH
`define RAW_PARAMS_SVH
`define RAW_ADDR_W 17
`define RAW_OFS_FLAGS 17'h1FFF0
`define RAW_OFS_ALM_SEC 17'h1FFF2
`define RAW_OFS_ALM_DATE 17'h1FFF5
`define RAW_OFS_ENABLES 17'h1FFF6
`define RAW_OFS_WDOG 17'h1FFF7
`define RAW_OFS_SECONDS 17'h1FFF9
`define RAW_OFS_DAY 17'h1FFFC
`define RAW_FLG_WF 7
`define RAW_FLG_AF 6
`define RAW_EN_AE 7
`define RAW_EN_ABE 5
`define RAW_WD_STEER 7
`define RAW_ALM_MASK 7
`define RAW_SEC_OSC 7
`define RAW_DAY_FT 6
`define RAW_EN_RST 8'h00
`define RAW_WD_RST 8'h00
`define RAW_ALM_RST 8'h00
`define RAW_OSC_STOP_RST 1'b1
`define RAW_FT_RST 1'b0
`define RAW_CLK_HZ 250000000
`define RAW_OSC_HZ 32768
`define RAW_SQ_HALF_LOG2 5
`define RAW_PRE_W 17
`define RAW_RES_LOG2 '{11, 13, 15, 17}
`define RAW_RST_PULSE_MS 40
`define RAW_RST_PULSE_CYC ((64'(`RAW_RST_PULSE_MS) * 64'(`RAW_CLK_HZ) + 64'd999) / 64'd1000)
`endif

// ===== include/raw_pkg.sv
// types shared by the alarm/watchdog block
`include "raw_params.svh"
package raw_pkg;
	typedef logic [7:0] raw_byte_t;
	typedef logic [`RAW_ADDR_W-1:0] raw_addr_t;
	typedef enum logic [2:0] {
		WD_OFF = 3'b001,
		WD_RUN = 3'b010,
		WD_PULSE = 3'b100
	} raw_wd_state_e;
endpackage

// ===== logic/raw_alarm_wdog.sv
// alarm, watchdog and frequency-test logic behind the asynchronous memory bus
//
// Contract
// - square wave at 512 Hz under test conditions
// - power-up clears the frequency test bit
// - mask bits pick the alarm match fields
// - undefined mask codes alarm every second
// - alarm match sets flag, enable drives interrupt
// - flags access releases the alarm interrupt
// - flags access clears flag after cycle ends
// - on battery alarm needs both enables
// - power-up clears enables, alarm still flags
// - multiplier and resolution fields of watchdog
// - timeout equals multiplier times resolution
// - expiry sets flag, interrupt held until access
// - steer zero sends expiry to interrupt
// - steer one gives 40 ms reset pulse
// - after pulse, watchdog and test bit cleared
// - watchdog access restarts the count
// - zero watchdog register disables the timer
// - power-up clears watchdog and alarm enables
// - watchdog steered to interrupt with a nonzero register suppresses the test wave
// - seconds top bit stops the oscillator
`timescale 1ns/1ps
`default_nettype none
`include "raw_params.svh"
module raw_alarm_wdog import raw_pkg::*; #(
	parameter int unsigned RST_PULSE_CYC = 32'(`RAW_RST_PULSE_CYC),
	parameter int unsigned CLK_HZ = `RAW_CLK_HZ,
	parameter int unsigned OSC_HZ = `RAW_OSC_HZ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic [`RAW_ADDR_W-1:0] addr_i,
	input wire logic [7:0] dq_i,
	output logic [7:0] dq_o,
	output logic dq_oe_o,
	output logic irq_or_test_out_o,
	output logic irq_or_test_out_oe_o,
	output logic reset_n_o,
	output logic reset_n_oe_o,
	input wire logic power_up_i,
	input wire logic on_battery_i,
	input wire logic sec_tick_i,
	input wire logic [7:0] time_sec_i,
	input wire logic [7:0] time_min_i,
	input wire logic [7:0] time_hour_i,
	input wire logic [7:0] time_date_i,
	output logic osc_stop_o,
	output logic freq_test_o
);
	raw_core_if cif();
	raw_osc_div #(.CLK_HZ(CLK_HZ), .OSC_HZ(OSC_HZ)) u_div (.clk_i(clk_i), .rst_i(rst_i), .cif(cif));
	raw_pulse_timer #(.LEN(RST_PULSE_CYC)) u_pulse (.clk_i(clk_i), .rst_i(rst_i), .cif(cif));

	////////////////////////////////////////////////////////////////////////////////
	// pin synchroniser and bus cycle tracking
	logic [29:0] pin_m_q, pin_s_q;
	logic ce_s, oe_s, we_s, pwr_s, bat_s;
	raw_addr_t addr_s, addr_q, addr_d;
	raw_byte_t dq_s, wdata_q, wdata_d;
	logic acc_now, acc_q, wr_q, wr_d, acc_start, acc_end;
	logic flags_start, wd_start, flags_end, wd_end, wr_end;

	assign {ce_s, oe_s, we_s, addr_s, dq_s, pwr_s, bat_s} = pin_s_q;
	assign acc_now = !ce_s && (!oe_s || !we_s);
	assign acc_start = acc_now && !acc_q;
	assign acc_end = !acc_now && acc_q;
	assign flags_start = acc_start && (addr_s == `RAW_OFS_FLAGS);
	assign wd_start = acc_start && (addr_s == `RAW_OFS_WDOG);
	assign flags_end = acc_end && (addr_q == `RAW_OFS_FLAGS);
	assign wd_end = acc_end && (addr_q == `RAW_OFS_WDOG);
	assign wr_end = acc_end && wr_q;

	always_comb begin
		addr_d = addr_q;
		wdata_d = wdata_q;
		wr_d = wr_q;
		if (acc_now) begin
			addr_d = addr_s;
			wr_d = acc_start ? !we_s : (wr_q || !we_s);
			// the last sample before the write strobe rises is the one committed
			if (!we_s) begin
				wdata_d = dq_s;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_m_q <= 30'h3800_0000;
			pin_s_q <= 30'h3800_0000;
			acc_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= 8'h00;
			wr_q <= 1'b0;
		end else begin
			pin_m_q <= {ce_n_i, oe_n_i, we_n_i, addr_i, dq_i, power_up_i, on_battery_i};
			pin_s_q <= pin_m_q;
			acc_q <= acc_now;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			wr_q <= wr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers, alarm and watchdog
	raw_byte_t en_q, en_d, wd_cfg_q, wd_cfg_d;
	raw_byte_t alm_q [4];
	raw_byte_t alm_d [4];
	logic af_q, af_d, wf_q, wf_d, alarm_irq_q, alarm_irq_d, wd_irq_q, wd_irq_d;
	logic osc_stop_q, osc_stop_d, ft_q, ft_d;
	raw_wd_state_e wd_st_q, wd_st_d;
	logic [4:0] wd_cnt_q, wd_cnt_d, mult;
	logic [1:0] res;
	logic [3:0] mask;
	logic [2:0] alm_idx;
	logic alm_hit, alarm_evt, wd_en, wd_tick, wd_expire, restart, pulse_start;

	assign mult = wd_cfg_q[6:2];
	assign res = wd_cfg_q[1:0];
	assign wd_en = (wd_cfg_q != 8'h00) && (mult != 5'h00);
	assign wd_tick = cif.res_tick[res];
	assign mask = {alm_q[3][`RAW_ALM_MASK], alm_q[2][`RAW_ALM_MASK],
		alm_q[1][`RAW_ALM_MASK], alm_q[0][`RAW_ALM_MASK]};
	assign alm_idx = addr_q[2:0] - 3'h2;

	always_comb begin
		case (mask)
			4'hE: alm_hit = alm_q[0][6:0] == time_sec_i[6:0];
			4'hC: alm_hit = alm_q[0][6:0] == time_sec_i[6:0]
				&& alm_q[1][6:0] == time_min_i[6:0];
			4'h8: alm_hit = alm_q[0][6:0] == time_sec_i[6:0]
				&& alm_q[1][6:0] == time_min_i[6:0]
				&& alm_q[2][5:0] == time_hour_i[5:0];
			4'h0: alm_hit = alm_q[0][6:0] == time_sec_i[6:0]
				&& alm_q[1][6:0] == time_min_i[6:0]
				&& alm_q[2][5:0] == time_hour_i[5:0]
				&& alm_q[3][5:0] == time_date_i[5:0];
			default: alm_hit = 1'b1;
		endcase
		alarm_evt = sec_tick_i && !osc_stop_q && alm_hit;
	end

	always_comb begin
		en_d = en_q;
		wd_cfg_d = wd_cfg_q;
		alm_d = alm_q;
		osc_stop_d = osc_stop_q;
		ft_d = ft_q;
		af_d = af_q;
		wf_d = wf_q;
		alarm_irq_d = alarm_irq_q;
		wd_irq_d = wd_irq_q;
		wd_st_d = wd_st_q;
		wd_cnt_d = wd_cnt_q;
		restart = 1'b0;
		pulse_start = 1'b0;
		wd_expire = 1'b0;
		if (wr_end) begin
			if (addr_q == `RAW_OFS_ENABLES) en_d = wdata_q;
			if (addr_q == `RAW_OFS_WDOG) wd_cfg_d = wdata_q;
			if (addr_q == `RAW_OFS_SECONDS) osc_stop_d = wdata_q[`RAW_SEC_OSC];
			if (addr_q == `RAW_OFS_DAY) ft_d = wdata_q[`RAW_DAY_FT];
			if (addr_q >= `RAW_OFS_ALM_SEC && addr_q <= `RAW_OFS_ALM_DATE) begin
				alm_d[alm_idx[1:0]] = wdata_q;
			end
		end
		// clears first so that a coinciding event still lands
		if (flags_end) begin
			af_d = 1'b0;
			wf_d = 1'b0;
		end
		if (flags_start) alarm_irq_d = 1'b0;
		if (flags_start || wd_start) wd_irq_d = 1'b0;
		if (alarm_evt) begin
			af_d = 1'b1;
			if (en_q[`RAW_EN_AE] && (!bat_s || en_q[`RAW_EN_ABE])) alarm_irq_d = 1'b1;
		end
		unique case (wd_st_q)
			WD_OFF: begin
				if (wd_en && !pwr_s) begin
					wd_st_d = WD_RUN;
					wd_cnt_d = 5'h00;
					restart = 1'b1;
				end
			end
			WD_RUN: begin
				if (!wd_en || pwr_s) begin
					wd_st_d = WD_OFF;
				end else if (wd_start || wd_end) begin
					wd_cnt_d = 5'h00;
					restart = 1'b1;
				end else if (wd_tick) begin
					wd_cnt_d = wd_cnt_q + 5'h01;
					if (5'(wd_cnt_q + 5'h01) == mult) begin
						wd_expire = 1'b1;
						wd_cnt_d = 5'h00;
						restart = 1'b1;
						wf_d = 1'b1;
						if (wd_cfg_q[`RAW_WD_STEER]) begin
							wd_st_d = WD_PULSE;
							pulse_start = 1'b1;
						end else begin
							wd_irq_d = 1'b1;
						end
					end
				end
			end
			WD_PULSE: begin
				if (cif.pulse_done) begin
					wd_cfg_d = 8'h00;
					ft_d = 1'b0;
					wd_st_d = WD_OFF;
				end
			end
		endcase
		if (pwr_s) begin
			en_d = 8'h00;
			wd_cfg_d = 8'h00;
			ft_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_q <= `RAW_EN_RST;
			wd_cfg_q <= `RAW_WD_RST;
			alm_q <= '{default: `RAW_ALM_RST};
			osc_stop_q <= `RAW_OSC_STOP_RST;
			ft_q <= `RAW_FT_RST;
			af_q <= 1'b0;
			wf_q <= 1'b0;
			alarm_irq_q <= 1'b0;
			wd_irq_q <= 1'b0;
			wd_st_q <= WD_OFF;
			wd_cnt_q <= 5'h00;
		end else begin
			en_q <= en_d;
			wd_cfg_q <= wd_cfg_d;
			alm_q <= alm_d;
			osc_stop_q <= osc_stop_d;
			ft_q <= ft_d;
			af_q <= af_d;
			wf_q <= wf_d;
			alarm_irq_q <= alarm_irq_d;
			wd_irq_q <= wd_irq_d;
			wd_st_q <= wd_st_d;
			wd_cnt_q <= wd_cnt_d;
		end
	end

	assign cif.run = !osc_stop_q;
	assign cif.restart = restart;
	assign cif.pulse_start = pulse_start;

	////////////////////////////////////////////////////////////////////////////////
	// pin outputs
	raw_byte_t rd_mux;
	logic rd_hit, test_en, irq_oe_d;

	// a steered-to-interrupt watchdog that is armed wins over the test wave
	assign test_en = ft_q && !en_q[`RAW_EN_AE] && !osc_stop_q
		&& (wd_cfg_q[`RAW_WD_STEER] || wd_cfg_q == 8'h00);
	assign irq_oe_d = alarm_irq_q || wd_irq_q || (test_en && !cif.sq_wave);

	always_comb begin
		rd_hit = 1'b1;
		rd_mux = 8'h00;
		if (addr_s == `RAW_OFS_FLAGS) begin
			rd_mux[`RAW_FLG_WF] = wf_q;
			rd_mux[`RAW_FLG_AF] = af_q;
		end else if (addr_s == `RAW_OFS_ENABLES) begin
			rd_mux = en_q;
		end else if (addr_s == `RAW_OFS_WDOG) begin
			rd_mux = wd_cfg_q;
		end else if (addr_s >= `RAW_OFS_ALM_SEC && addr_s <= `RAW_OFS_ALM_DATE) begin
			rd_mux = alm_q[2'(addr_s[2:0] - 3'h2)];
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dq_o <= 8'h00;
			dq_oe_o <= 1'b0;
			irq_or_test_out_o <= 1'b0;
			irq_or_test_out_oe_o <= 1'b0;
			reset_n_o <= 1'b0;
			reset_n_oe_o <= 1'b0;
			osc_stop_o <= `RAW_OSC_STOP_RST;
			freq_test_o <= `RAW_FT_RST;
		end else begin
			dq_o <= rd_mux;
			dq_oe_o <= acc_now && !oe_s && we_s && rd_hit;
			irq_or_test_out_o <= 1'b0;
			irq_or_test_out_oe_o <= irq_oe_d;
			reset_n_o <= 1'b0;
			reset_n_oe_o <= cif.pulse_busy;
			osc_stop_o <= osc_stop_q;
			freq_test_o <= ft_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_flags_touch;
		flags_start && !alarm_evt;
	endsequence
	sequence s_expire_steered;
		wd_expire && wd_cfg_q[`RAW_WD_STEER];
	endsequence

	a_flag_irq_release: assert property (s_flags_touch |=> !alarm_irq_q)
		else $error("alarm interrupt not released by flags access");
	a_flag_clear_late: assert property ($fell(af_q) |-> $past(flags_end))
		else $error("alarm flag cleared outside end of flags cycle");
	a_alarm_sets_flag: assert property (alarm_evt |=> af_q)
		else $error("alarm match did not set flag");
	a_alarm_irq_gate: assert property ($rose(alarm_irq_q) |->
		$past(en_q[`RAW_EN_AE] && (!bat_s || en_q[`RAW_EN_ABE])))
		else $error("alarm interrupt without enables");
	a_wd_expire_flag: assert property (wd_expire |=> wf_q)
		else $error("watchdog expiry did not set flag");
	a_wd_rst_pulse: assert property (s_expire_steered |=> ##1 reset_n_oe_o ##1 reset_n_oe_o)
		else $error("steered expiry gave no reset pulse");
	a_wd_irq_route: assert property (wd_expire && !wd_cfg_q[`RAW_WD_STEER] |=> ##1 irq_or_test_out_oe_o)
		else $error("expiry not routed to interrupt output");
	a_wd_cfg_clear: assert property (cif.pulse_done && !pwr_s |=> wd_cfg_q == 8'h00 && !ft_q)
		else $error("watchdog register not cleared after pulse");
	a_pwr_clears: assert property (pwr_s |=> en_q == 8'h00 && wd_cfg_q == 8'h00 && !ft_q)
		else $error("power-up did not clear enables");
	a_wd_restart: assert property (wd_st_q == WD_RUN && wd_en && !pwr_s && wd_start |=> wd_cnt_q == 5'h00)
		else $error("watchdog access did not restart count");
	a_test_suppress: assert property (irq_or_test_out_oe_o && !$past(alarm_irq_q) && !$past(wd_irq_q)
		|-> $past(test_en))
		else $error("test wave driven while suppressed");
endmodule
`default_nettype wire

// ===== logic/raw_osc_div.sv
// 32.768 kHz oscillator derived from the system clock, 512 Hz wave and resolution ticks
`timescale 1ns/1ps
`default_nettype none
`include "raw_params.svh"
module raw_osc_div import raw_pkg::*; #(
	parameter int unsigned CLK_HZ = `RAW_CLK_HZ,
	parameter int unsigned OSC_HZ = `RAW_OSC_HZ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	raw_core_if.div cif
);
	localparam int RES_LOG2 [4] = `RAW_RES_LOG2;
	logic [31:0] ph_q, ph_d, sum;
	logic [`RAW_PRE_W-1:0] pre_q, pre_d;
	logic [`RAW_SQ_HALF_LOG2-1:0] sq_cnt_q, sq_cnt_d;
	logic sq_q, sq_d, tick;

	// fractional accumulator: the average tick rate is exact, jitter is one clock
	always_comb begin
		sum = ph_q + 32'(OSC_HZ);
		tick = cif.run && (sum >= 32'(CLK_HZ));
		ph_d = ph_q;
		pre_d = pre_q;
		sq_cnt_d = sq_cnt_q;
		sq_d = sq_q;
		if (cif.run) begin
			ph_d = tick ? sum - 32'(CLK_HZ) : sum;
		end
		if (tick) begin
			sq_cnt_d = sq_cnt_q + 1'b1;
			if (&sq_cnt_q) begin
				sq_d = !sq_q;
			end
			pre_d = pre_q + 1'b1;
		end
		// restart keeps the square wave running, only the prescaler starts over
		if (cif.restart) begin
			pre_d = '0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ph_q <= '0;
			pre_q <= '0;
			sq_cnt_q <= '0;
			sq_q <= 1'b1;
		end else begin
			ph_q <= ph_d;
			pre_q <= pre_d;
			sq_cnt_q <= sq_cnt_d;
			sq_q <= sq_d;
		end
	end

	assign cif.osc_tick = tick;
	assign cif.sq_wave = sq_q;
	for (genvar k = 0; k < 4; k++) begin : g_res
		// restart is not folded in here: the core derives restart from these ticks,
		// and a restart already takes priority over a tick in the core
		assign cif.res_tick[k] = tick && (&pre_q[RES_LOG2[k]-1:0]);
	end
endmodule
`default_nettype wire

// ===== logic/raw_pulse_timer.sv
// fixed-length pulse for the reset output
`timescale 1ns/1ps
`default_nettype none
`include "raw_params.svh"
module raw_pulse_timer #(
	parameter int unsigned LEN = 32'(`RAW_RST_PULSE_CYC)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	raw_core_if.pulse cif
);
	localparam int W = $clog2(LEN + 1);
	logic [W-1:0] cnt_q, cnt_d;
	logic busy_q, busy_d, done;

	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		done = busy_q && (cnt_q == W'(LEN - 1));
		if (busy_q) begin
			cnt_d = cnt_q + 1'b1;
			if (done) begin
				busy_d = 1'b0;
			end
		end else if (cif.pulse_start) begin
			busy_d = 1'b1;
			cnt_d = '0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
		end
	end

	assign cif.pulse_busy = busy_q;
	assign cif.pulse_done = done;
endmodule
`default_nettype wire
